// ===== lsr_serial_port.sv
// Serial slave port and control register bank of the lens motor driver
//
// Contract
// - A frame is the interval with chip select high.
// - One data set is exactly 24 serial clock periods.
// - Input bits are sampled on serial clock rising edges while selected.
// - Read bits are driven in step with serial clock rising edges.
// - Output released when deselected; drives zero when selected except readout.
// - Bit counter and shift state held cleared while chip select is low.
// - Bits 0-5 address LSB first, 6 read/write, 7 spare, 8-23 data.
// - Read/write bit zero writes, one reads; spare bit ignored.
// - Write data lands in the addressed register when the next set completes or the frame closes.
// - Write frame of 23 or fewer clocks changes no register.
// - Longer write frames write once per complete 24-bit set.
// - Trailing incomplete set is dropped, earlier sets stay written.
// - Read frame shifts the addressed 16-bit value out LSB first.
// - Data bits sent by the host during a read are ignored.
// - Reset pin low clears the serial logic and the whole bank.
// - Address 0Ch is read only, bits 9:0 show iris feedback result.
// - Pulse registers: bit 15 enable, 12 or 6 bit width, 10 bit start.
// - Motor control: division 13:12, LED 11, enable 10, brake 9, dir 8, steps 7:0.
// - Bit 10 of 0Ah bypasses iris loop with duty from bits 9:0.
`timescale 1ns/1ns
`default_nettype none
`include "lsr_regs.svh"

module lsr_serial_port (
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic reset_in_n, // Reset pin, active low
  input wire logic chip_select_in, // Chip select pin, active high
  input wire logic serial_clock_in, // Serial clock pin
  input wire logic serial_data_in, // Serial data pin
  output logic serial_data_out, // Serial data output level
  output logic serial_data_out_en, // Serial data output enable
  input wire logic [9:0] irisFeedback, // Latest iris conversion result
  input wire logic [9:0] irisLoopDuty, // Duty from the iris control loop
  output logic [9:0] irisDuty, // Duty applied to the iris output
  output lsr_pkg::lsr_pulse_one_s pulseOne, // Pulse one settings
  output lsr_pkg::lsr_pulse_two_s pulseTwo, // Pulse two settings
  output lsr_pkg::lsr_motor_s motorOne, // Motor one control
  output lsr_pkg::lsr_motor_s motorTwo // Motor two control
);

  // Pin synchronisers
  logic csS1_q, csS2_q, csD_q;
  logic sckS1_q, sckS2_q, sckD_q;
  logic sdiS1_q, sdiS2_q;
  logic rstnS1_q, rstnS2_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      csS1_q <= 1'b0;
      csS2_q <= 1'b0;
      csD_q <= 1'b0;
      sckS1_q <= 1'b0;
      sckS2_q <= 1'b0;
      sckD_q <= 1'b0;
      sdiS1_q <= 1'b0;
      sdiS2_q <= 1'b0;
      rstnS1_q <= 1'b0;
      rstnS2_q <= 1'b0;
    end else begin
      csS1_q <= chip_select_in;
      csS2_q <= csS1_q;
      csD_q <= csS2_q;
      sckS1_q <= serial_clock_in;
      sckS2_q <= sckS1_q;
      sckD_q <= sckS2_q;
      sdiS1_q <= serial_data_in;
      sdiS2_q <= sdiS1_q;
      rstnS1_q <= reset_in_n;
      rstnS2_q <= rstnS1_q;
    end
  end

  wire logic bankClr = ~rstnS2_q;
  wire logic frameOn = csS2_q & rstnS2_q;
  wire logic csFall = csD_q & ~csS2_q;
  wire logic sckRise = frameOn & sckS2_q & ~sckD_q;

  // Frame state
  logic [4:0] bitCnt_q;
  logic [23:0] shiftIn_q;
  logic [23:0] pend_q;
  logic pendValid_q;
  logic [15:0] outShift_q;
  logic readActive_q;
  logic sdoOe_q;

  wire logic [23:0] newShift = {sdiS2_q, shiftIn_q[23:1]};
  wire logic addrDone = sckRise && (bitCnt_q == `LSR_CNT_ADDR_LAST);
  wire logic setDone = sckRise && (bitCnt_q == `LSR_CNT_FRAME_LAST);
  wire logic [5:0] headAddr = newShift[21:16];
  wire logic headRead = newShift[22];
  wire logic setIsWrite = ~newShift[`LSR_POS_RW];
  wire logic readLoad = addrDone && headRead;

  // Bank write port
  wire logic wrEn = pendValid_q && (setDone || csFall);
  wire logic [5:0] wrAddr = pend_q[`LSR_POS_ADDR +: 6];
  wire logic [15:0] wrData = pend_q[`LSR_POS_DATA +: 16];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bitCnt_q <= 5'h00;
      shiftIn_q <= 24'h000000;
    end else if (!frameOn) begin
      bitCnt_q <= 5'h00;
      shiftIn_q <= 24'h000000;
    end else if (sckRise) begin
      bitCnt_q <= setDone ? 5'h00 : bitCnt_q + 5'h01;
      shiftIn_q <= newShift;
    end
  end

  // Holds the last complete write set until the frame closes or another arrives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 24'h000000;
      pendValid_q <= 1'b0;
    end else if (!frameOn) begin
      pendValid_q <= 1'b0;
    end else if (setDone) begin
      pend_q <= newShift;
      pendValid_q <= setIsWrite;
    end
  end

  // Register bank
  logic [15:0] bank_q [0:63];

  function automatic logic [15:0] wrMask(input logic [5:0] a);
    case (a)
      `LSR_ADDR_IRIS_PID_SHAPE: wrMask = `LSR_MASK_FULL;
      `LSR_ADDR_IRIS_PWM_CONFIG: wrMask = `LSR_MASK_IRIS_PWM_CONFIG;
      `LSR_ADDR_HALL_DAC_LEVELS: wrMask = `LSR_MASK_FULL;
      `LSR_ADDR_HALL_AMP_TARGET_FILTER: wrMask = `LSR_MASK_HALL_AMP_TARGET_FILTER;
      `LSR_ADDR_PULSE_ONE_START: wrMask = `LSR_MASK_START;
      `LSR_ADDR_PULSE_ONE_WIDTH_ENABLE: wrMask = `LSR_MASK_PULSE_ONE_WIDTH_ENABLE;
      `LSR_ADDR_PULSE_TWO_START: wrMask = `LSR_MASK_START;
      `LSR_ADDR_PULSE_TWO_WIDTH_ENABLE: wrMask = `LSR_MASK_PULSE_TWO_WIDTH_ENABLE;
      `LSR_ADDR_IRIS_DIRECT_DUTY: wrMask = `LSR_MASK_IRIS_DIRECT_DUTY;
      `LSR_ADDR_IRIS_MODE_CONTROL: wrMask = `LSR_MASK_IRIS_MODE_CONTROL;
      `LSR_ADDR_IRIS_TARGET_SMOOTHING: wrMask = `LSR_MASK_IRIS_TARGET_SMOOTHING;
      `LSR_ADDR_MICROSTEP_PWM_CONFIG: wrMask = `LSR_MASK_MICROSTEP_PWM_CONFIG;
      `LSR_ADDR_PULSE_PIN_TEST_SELECT: wrMask = `LSR_MASK_PULSE_PIN_TEST_SELECT;
      `LSR_ADDR_MOTOR_ONE_PHASE_WAIT: wrMask = `LSR_MASK_FOURTEEN;
      `LSR_ADDR_DRIVER_AB_PEAK_WIDTH: wrMask = `LSR_MASK_FULL;
      `LSR_ADDR_MOTOR_ONE_CONTROL: wrMask = `LSR_MASK_FOURTEEN;
      `LSR_ADDR_MOTOR_ONE_STEP_PERIOD: wrMask = `LSR_MASK_FULL;
      `LSR_ADDR_MOTOR_TWO_PHASE_WAIT: wrMask = `LSR_MASK_FOURTEEN;
      `LSR_ADDR_DRIVER_CD_PEAK_WIDTH: wrMask = `LSR_MASK_FULL;
      `LSR_ADDR_MOTOR_TWO_CONTROL: wrMask = `LSR_MASK_FOURTEEN;
      `LSR_ADDR_MOTOR_TWO_STEP_PERIOD: wrMask = `LSR_MASK_FULL;
      default: wrMask = `LSR_MASK_NONE;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : gBank
      localparam logic [5:0] IDX = 6'(gi);
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          bank_q[gi] <= `LSR_RST_VAL;
        end else if (bankClr) begin
          bank_q[gi] <= `LSR_RST_VAL;
        end else if (wrEn && wrAddr == IDX) begin
          bank_q[gi] <= wrData & wrMask(IDX);
        end
      end
    end
  endgenerate

  // Read selection
  wire logic isFeedback = headAddr == `LSR_ADDR_IRIS_FEEDBACK_RESULT;
  wire logic [15:0] bankWord = bank_q[headAddr] & wrMask(headAddr);
  wire logic [15:0] rdData = isFeedback ? {6'h00, irisFeedback} : bankWord;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outShift_q <= 16'h0000;
      readActive_q <= 1'b0;
      sdoOe_q <= 1'b0;
    end else begin
      sdoOe_q <= frameOn;
      if (!frameOn) begin
        outShift_q <= 16'h0000;
        readActive_q <= 1'b0;
      end else if (readLoad) begin
        outShift_q <= rdData;
        readActive_q <= 1'b1;
      end else if (sckRise) begin
        outShift_q <= {1'b0, outShift_q[15:1]};
        if (setDone) begin
          readActive_q <= 1'b0;
        end
      end
    end
  end

  assign serial_data_out = readActive_q & outShift_q[0];
  assign serial_data_out_en = sdoOe_q;

  // Field views of the bank
  wire logic [15:0] p1Start = bank_q[`LSR_ADDR_PULSE_ONE_START];
  wire logic [15:0] p1Width = bank_q[`LSR_ADDR_PULSE_ONE_WIDTH_ENABLE];
  wire logic [15:0] p2Start = bank_q[`LSR_ADDR_PULSE_TWO_START];
  wire logic [15:0] p2Width = bank_q[`LSR_ADDR_PULSE_TWO_WIDTH_ENABLE];
  wire logic [15:0] m1Ctl = bank_q[`LSR_ADDR_MOTOR_ONE_CONTROL];
  wire logic [15:0] m2Ctl = bank_q[`LSR_ADDR_MOTOR_TWO_CONTROL];
  wire logic [15:0] dutyReg = bank_q[`LSR_ADDR_IRIS_DIRECT_DUTY];
  wire logic bypass = dutyReg[`LSR_POS_BYPASS];

  assign pulseOne = '{enable: p1Width[15], width: p1Width[11:0], start: p1Start[9:0]};
  assign pulseTwo = '{enable: p2Width[15], width: p2Width[5:0], start: p2Start[9:0]};
  assign motorOne = '{sineDivision: m1Ctl[13:12], led: m1Ctl[11], enable: m1Ctl[10],
                      brake: m1Ctl[9], direction: m1Ctl[8], stepCount: m1Ctl[7:0]};
  assign motorTwo = '{sineDivision: m2Ctl[13:12], led: m2Ctl[11], enable: m2Ctl[10],
                      brake: m2Ctl[9], direction: m2Ctl[8], stepCount: m2Ctl[7:0]};
  assign irisDuty = bypass ? dutyReg[9:0] : irisLoopDuty;

  // Checks
  sdo_release_a: assert property (@(posedge clock) disable iff (rst)
    !csS2_q |=> !serial_data_out_en) else $error("output not released");
  write_zero_a: assert property (@(posedge clock) disable iff (rst)
    !readActive_q |-> !serial_data_out) else $error("output not zero outside readout");
  cnt_hold_a: assert property (@(posedge clock) disable iff (rst)
    !frameOn |=> bitCnt_q == 5'h00 && !readActive_q) else $error("counter not held");
  cnt_step_a: assert property (@(posedge clock) disable iff (rst)
    sckRise && bitCnt_q != `LSR_CNT_FRAME_LAST |=> bitCnt_q == $past(bitCnt_q) + 5'h01)
    else $error("bit counter did not step");
  close_commit_a: assert property (@(posedge clock) disable iff (rst)
    csFall && pendValid_q |=> bank_q[$past(wrAddr)] == ($past(wrData) & wrMask($past(wrAddr))))
    else $error("write not committed at close");
  short_frame_a: assert property (@(posedge clock) disable iff (rst)
    wrEn |-> pendValid_q && $past(csS2_q, 2)) else $error("write without complete set");
  chain_write_a: assert property (@(posedge clock) disable iff (rst)
    setDone && pendValid_q |-> wrEn) else $error("continuous set lost");
  read_nowrite_a: assert property (@(posedge clock) disable iff (rst)
    setDone && !setIsWrite |=> !pendValid_q) else $error("read set queued as write");
  lsb_first_a: assert property (@(posedge clock) disable iff (rst)
    readLoad |=> serial_data_out == $past(rdData[0]) ##1 readActive_q)
    else $error("read data not LSB first");
  feed_read_a: assert property (@(posedge clock) disable iff (rst)
    readLoad && isFeedback |=> outShift_q == {6'h00, $past(irisFeedback)})
    else $error("feedback register misread");
  bank_clear_a: assert property (@(posedge clock) disable iff (rst)
    bankClr |=> motorOne == '0 && pulseOne == '0) else $error("bank not cleared");
  duty_bypass_a: assert property (@(posedge clock) disable iff (rst)
    $rose(bypass) |-> irisDuty == dutyReg[9:0]) else $error("bypass duty wrong");
  loop_duty_a: assert property (@(posedge clock) disable iff (rst)
    !bypass |-> irisDuty == irisLoopDuty)
    else $error("loop duty not passed through");
  bit_sample_a: assert property (@(posedge clock) disable iff (rst)
    sckRise |=> shiftIn_q[23] == $past(sdiS2_q))
    else $error("serial bit not sampled");
  read_start_a: assert property (@(posedge clock) disable iff (rst)
    readLoad |=> readActive_q)
    else $error("readout not started after address");
  read_end_a: assert property (@(posedge clock) disable iff (rst)
    setDone && readActive_q && !readLoad |=> !readActive_q)
    else $error("readout ran past its set");
  read_shift_a: assert property (@(posedge clock) disable iff (rst)
    sckRise && readActive_q && frameOn |=> outShift_q == {1'b0, $past(outShift_q[15:1])})
    else $error("read bit not advanced");
  pend_drop_a: assert property (@(posedge clock) disable iff (rst)
    !frameOn |=> !pendValid_q)
    else $error("partial set kept after close");
  ro_feedback_a: assert property (@(posedge clock) disable iff (rst)
    bank_q[`LSR_ADDR_IRIS_FEEDBACK_RESULT] == 16'h0000)
    else $error("read only address written");
  unmapped_zero_a: assert property (@(posedge clock) disable iff (rst)
    bank_q[6'h01] == 16'h0000 && bank_q[6'h3f] == 16'h0000)
    else $error("unmapped address holds data");
  pin_reset_a: assert property (@(posedge clock) disable iff (rst)
    bankClr |=> bitCnt_q == 5'h00 && !pendValid_q)
    else $error("serial logic not cleared by pin");
  motor_two_a: assert property (@(posedge clock) disable iff (rst)
    bankClr |=> motorTwo == '0 && pulseTwo == '0)
    else $error("second bank fields not cleared");

endmodule // lsr_serial_port

`default_nettype wire

// ===== lsr_regs.svh
// Register offsets, writable masks, reset values and frame counts of the lens serial port
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH

`define LSR_ADDR_IRIS_PID_SHAPE 6'h02
`define LSR_ADDR_IRIS_PWM_CONFIG 6'h03
`define LSR_ADDR_HALL_DAC_LEVELS 6'h04
`define LSR_ADDR_HALL_AMP_TARGET_FILTER 6'h05
`define LSR_ADDR_PULSE_ONE_START 6'h06
`define LSR_ADDR_PULSE_ONE_WIDTH_ENABLE 6'h07
`define LSR_ADDR_PULSE_TWO_START 6'h08
`define LSR_ADDR_PULSE_TWO_WIDTH_ENABLE 6'h09
`define LSR_ADDR_IRIS_DIRECT_DUTY 6'h0a
`define LSR_ADDR_IRIS_MODE_CONTROL 6'h0b
`define LSR_ADDR_IRIS_FEEDBACK_RESULT 6'h0c
`define LSR_ADDR_IRIS_TARGET_SMOOTHING 6'h0e
`define LSR_ADDR_MICROSTEP_PWM_CONFIG 6'h20
`define LSR_ADDR_PULSE_PIN_TEST_SELECT 6'h21
`define LSR_ADDR_MOTOR_ONE_PHASE_WAIT 6'h22
`define LSR_ADDR_DRIVER_AB_PEAK_WIDTH 6'h23
`define LSR_ADDR_MOTOR_ONE_CONTROL 6'h24
`define LSR_ADDR_MOTOR_ONE_STEP_PERIOD 6'h25
`define LSR_ADDR_MOTOR_TWO_PHASE_WAIT 6'h27
`define LSR_ADDR_DRIVER_CD_PEAK_WIDTH 6'h28
`define LSR_ADDR_MOTOR_TWO_CONTROL 6'h29
`define LSR_ADDR_MOTOR_TWO_STEP_PERIOD 6'h2a

`define LSR_MASK_FULL 16'hffff
`define LSR_MASK_IRIS_PWM_CONFIG 16'h3fff
`define LSR_MASK_HALL_AMP_TARGET_FILTER 16'h1f3f
`define LSR_MASK_START 16'h03ff
`define LSR_MASK_PULSE_ONE_WIDTH_ENABLE 16'h8fff
`define LSR_MASK_PULSE_TWO_WIDTH_ENABLE 16'h803f
`define LSR_MASK_IRIS_DIRECT_DUTY 16'h07ff
`define LSR_MASK_IRIS_MODE_CONTROL 16'hff98
`define LSR_MASK_IRIS_TARGET_SMOOTHING 16'h1fff
`define LSR_MASK_MICROSTEP_PWM_CONFIG 16'h7fff
`define LSR_MASK_PULSE_PIN_TEST_SELECT 16'h009f
`define LSR_MASK_FOURTEEN 16'h3fff
`define LSR_MASK_NONE 16'h0000

`define LSR_RST_VAL 16'h0000

`define LSR_POS_RW 6
`define LSR_POS_ADDR 0
`define LSR_POS_DATA 8
`define LSR_POS_BYPASS 10
`define LSR_CNT_ADDR_LAST 5'h07
`define LSR_CNT_FRAME_LAST 5'h17

`endif

// ===== lsr_pkg.sv
// Types shared by the lens serial register port
package lsr_pkg;
  typedef logic [15:0] lsr_word_t;
  typedef struct packed {
    logic enable;
    logic [11:0] width;
    logic [9:0] start;
  } lsr_pulse_one_s;
  typedef struct packed {
    logic enable;
    logic [5:0] width;
    logic [9:0] start;
  } lsr_pulse_two_s;
  typedef struct packed {
    logic [1:0] sineDivision;
    logic led;
    logic enable;
    logic brake;
    logic direction;
    logic [7:0] stepCount;
  } lsr_motor_s;
endpackage

// ===== lsr_host_model.sv
// Host model that drives the lens serial port pins
`timescale 1ns/1ns
`default_nettype none

module lsr_host_model (
  output logic cs, // Chip select pin
  output logic sck, // Serial clock pin
  output logic sdi, // Serial data to device
  input wire logic sdoPin, // Resolved serial output pin
  input wire logic sdoEn // Device output enable
);
  int zeroErrs;

  initial begin
    cs = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
    zeroErrs = 0;
  end

  // Clock stands low outside frames; read bits taken just before each rise
  task automatic xfer(input logic [71:0] bits, input int n, input bit rd,
                      output logic [15:0] q);
    q = 16'h0000;
    #100 cs = 1'b1;
    #100;
    for (int i = 0; i < n; i++) begin
      sdi = bits[i];
      #62;
      if (rd && i >= 8 && i < 24) q[i-8] = sdoPin;
      else if (sdoPin !== 1'b0 || sdoEn !== 1'b1) zeroErrs++;
      sck = 1'b1;
      #63 sck = 1'b0;
    end
    #100 cs = 1'b0;
    #100;
    if (sdoEn !== 1'b0) zeroErrs++;
  endtask
endmodule // lsr_host_model

`default_nettype wire

// ===== lens_driver_serial_register_port_tb.sv
// Testbench for the lens serial register port
`timescale 1ns/1ns
`default_nettype none

module lens_driver_serial_register_port_tb;
  logic clock, rst, resetInN, cs, sck, sdi, sdo, sdoEn, sdoPin, lastSdo;
  logic [9:0] irisFeedback, irisLoopDuty, irisDuty;
  lsr_pkg::lsr_pulse_one_s pulseOne;
  lsr_pkg::lsr_pulse_two_s pulseTwo;
  lsr_pkg::lsr_motor_s motorOne, motorTwo;
  logic [15:0] q;
  int nFail, totalChecks;
  logic [5:0] addrs [21] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a,
    6'h0b, 6'h0e, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h27, 6'h28, 6'h29, 6'h2a};
  logic [15:0] masks [21] = '{16'hffff, 16'h3fff, 16'hffff, 16'h1f3f, 16'h03ff, 16'h8fff,
    16'h03ff, 16'h803f, 16'h07ff, 16'hff98, 16'h1fff, 16'h7fff, 16'h009f, 16'h3fff, 16'hffff,
    16'h3fff, 16'hffff, 16'h3fff, 16'hffff, 16'h3fff, 16'hffff};

  // Undriven pin shows the inverse of its last driven level
  always @(sdo or sdoEn) if (sdoEn === 1'b1) lastSdo = sdo;
  assign sdoPin = (sdoEn === 1'b1) ? sdo : ~lastSdo;

  lsr_serial_port u_lsr_serial_port (.clock(clock), .rst(rst), .reset_in_n(resetInN),
    .chip_select_in(cs), .serial_clock_in(sck), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_en(sdoEn), .irisFeedback(irisFeedback),
    .irisLoopDuty(irisLoopDuty), .irisDuty(irisDuty), .pulseOne(pulseOne),
    .pulseTwo(pulseTwo), .motorOne(motorOne), .motorTwo(motorTwo));

  lsr_host_model u_lsr_host_model (.cs(cs), .sck(sck), .sdi(sdi), .sdoPin(sdoPin),
    .sdoEn(sdoEn));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic test_done();
    if (nFail == 0 && totalChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Spare bit set on writes, data bits set on reads: both must be ignored
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] unused;
    u_lsr_host_model.xfer({48'h0, d, 2'b10, a}, 24, 1'b0, unused);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_lsr_host_model.xfer({48'h0, 16'hffff, 2'b01, a}, 24, 1'b1, d);
    chk({16'h0, d}, {16'h0, exp}, "register read");
  endtask

  initial begin
    #600_000;
    nFail++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    rst = 1'b1;
    resetInN = 1'b1;
    irisFeedback = 10'h2a5;
    irisLoopDuty = 10'h0f0;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    for (int i = 0; i < 21; i++) begin
      rdchk(addrs[i], 16'h0000);
      wr(addrs[i], 16'hffff);
      rdchk(addrs[i], masks[i]);
    end
    chk({9'h0, pulseOne}, {9'h0, 1'b1, 12'hfff, 10'h3ff}, "pulse one");
    chk({15'h0, pulseTwo}, {15'h0, 1'b1, 6'h3f, 10'h3ff}, "pulse two");
    chk({18'h0, motorOne}, 32'h3fff, "motor one");
    chk({18'h0, motorTwo}, 32'h3fff, "motor two");
    chk({22'h0, irisDuty}, 32'h3ff, "direct duty");
    wr(6'h0a, 16'h0155);
    chk({22'h0, irisDuty}, {22'h0, irisLoopDuty}, "loop duty");
    wr(6'h24, 16'h2a5c);
    chk({18'h0, motorOne}, 32'h2a5c, "motor one fields");
    rdchk(6'h0c, 16'h02a5);
    wr(6'h0c, 16'hffff);
    @(posedge clock);
    #1 irisFeedback = 10'h15a;
    rdchk(6'h0c, 16'h015a);
    wr(6'h01, 16'hffff);
    rdchk(6'h01, 16'h0000);
    rdchk(6'h3f, 16'h0000);
    u_lsr_host_model.xfer({48'h0, 16'h1234, 8'h23}, 23, 1'b0, q);
    rdchk(6'h23, 16'hffff);
    u_lsr_host_model.xfer({14'h0, 10'h028, 16'h2222, 8'h25, 16'h1111, 8'h23}, 58, 1'b0, q);
    rdchk(6'h23, 16'h1111);
    rdchk(6'h25, 16'h2222);
    rdchk(6'h28, 16'hffff);
    @(posedge clock);
    #1 resetInN = 1'b0;
    repeat (5) @(posedge clock);
    #1 resetInN = 1'b1;
    repeat (4) @(posedge clock);
    chk({18'h0, motorOne}, 32'h0, "motor one cleared");
    rdchk(6'h02, 16'h0000);
    rdchk(6'h07, 16'h0000);
    chk(u_lsr_host_model.zeroErrs, 32'h0, "idle output level");
    test_done();
  end
endmodule // lens_driver_serial_register_port_tb

`default_nettype wire
